// file: src/fpau_regs.vh
// Constants for the fixed-point add unit: instruction fields, opcodes,
// register offsets, bit positions and reset values.
// Assumes 32-bit instruction words with bit 31 as the most significant bit.
`ifndef FPAU_REGS_VH
`define FPAU_REGS_VH

// Instruction fields, given as Verilog bit indices of the 32-bit word.
`define FPAU_PRIM_HI 31
`define FPAU_PRIM_LO 26
`define FPAU_DEST_HI 25
`define FPAU_DEST_LO 21
`define FPAU_SRCA_HI 20
`define FPAU_SRCA_LO 16
`define FPAU_SRCB_HI 15
`define FPAU_SRCB_LO 11
`define FPAU_OE_BIT 10
`define FPAU_XO_HI 9
`define FPAU_XO_LO 1
`define FPAU_REC_BIT 0
`define FPAU_IMM_HI 15
`define FPAU_IMM_LO 0
`define FPAU_IMM_SIGN 15

// Primary and extended opcodes.
`define FPAU_PRIM_EXT 6'h1f
`define FPAU_PRIM_ADDI 6'h0e
`define FPAU_PRIM_ADDIC 6'h0c
`define FPAU_PRIM_ADDICR 6'h0d
`define FPAU_XO_ADDE 9'h08a
`define FPAU_XO_ADDC 9'h00a
`define FPAU_REG_ZERO 5'h00

// Register byte offsets.
`define FPAU_OFF_FLAGS 8'h00
`define FPAU_OFF_STATUS 8'h04
`define FPAU_OFF_CLEAR 8'h08
`define FPAU_OFF_ENABLE 8'h0c

// Flags register layout.
`define FPAU_FLG_UWRAP 0
`define FPAU_FLG_SWRAP 1
`define FPAU_FLG_SO 2
`define FPAU_FLG_CR_LO 4
`define FPAU_FLG_CR_HI 7

// Event bits of status, clear and enable registers.
`define FPAU_EVT_OVF 0
`define FPAU_EVT_CARRY 1
`define FPAU_EVT_BADOP 2
`define FPAU_EVT_W 3

// Reset values.
`define FPAU_RST_EVT 3'h0
`define FPAU_RST_CR 4'h0
`define FPAU_RST_WORD 32'h0000_0000

`endif

// file: src/fpau_sum.v
// Adder core of the fixed-point add unit: sum, carry, overflow and the
// sign/zero classification of the result.
// Assumes operands already selected and extended by the caller.
`timescale 1ns/1ps
module fpau_sum #(
  parameter WIDTH = 32
) (
  input wire [WIDTH-1:0] opnd_a,
  input wire [WIDTH-1:0] opnd_b,
  input wire carry_in,
  output wire [WIDTH-1:0] sum,
  output wire carry_out,
  output wire overflow,
  output wire is_neg,
  output wire is_pos,
  output wire is_zero
);

  wire [WIDTH:0] wide_sum;

  // One extra bit catches the unsigned carry out of the top.
  assign wide_sum = {1'b0, opnd_a} + {1'b0, opnd_b} + {{WIDTH{1'b0}}, carry_in};
  assign sum = wide_sum[WIDTH-1:0];
  assign carry_out = wide_sum[WIDTH];

  // Signed overflow: like-signed operands giving a result of the other sign.
  assign overflow = (opnd_a[WIDTH-1] == opnd_b[WIDTH-1]) &&
                    (sum[WIDTH-1] != opnd_a[WIDTH-1]);

  // The result is classed as a signed number.
  assign is_neg = sum[WIDTH-1];
  assign is_zero = ~|sum;
  assign is_pos = ~is_neg & ~is_zero;

endmodule

// file: src/fpau_top.v
// Fixed-point add unit: decodes add-extended, add-carrying, add-immediate
// and add-immediate-carrying forms, keeps the wrap, summary and compare
// flags, and gives software an APB window onto those flags and events.
// Assumes operand values arrive from the register file with issue_valid
// and that the receiver takes each result in the cycle res_valid is high.
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "fpau_regs.vh"

module fpau_top #(
  parameter AW = 8,
  parameter DW = 32
) (
  input wire core_clk,
  input wire rst_n,
  // Register bus.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  output wire irq,
  // Issue side, from the decoder and the register file.
  input wire issue_valid,
  input wire [31:0] issue_instr,
  input wire [DW-1:0] src_first_val,
  input wire [DW-1:0] src_second_val,
  // Result towards the register file write port.
  output reg res_valid,
  output reg res_write,
  output reg [4:0] res_dest,
  output reg [DW-1:0] res_data,
  // Flag state, kept here and visible to the core.
  output reg cr0_update,
  output reg unsigned_wrap_bit,
  output reg signed_wrap_bit,
  output reg summary_bit,
  output reg neg_result_flag,
  output reg pos_result_flag,
  output reg zero_result_flag,
  output reg cr0_summary
);

  // One-hot operation kinds produced by the decoder.
  localparam K_ADDE = 6'b000001;
  localparam K_ADDC = 6'b000010;
  localparam K_ADDI = 6'b000100;
  localparam K_ADDIC = 6'b001000;
  localparam K_ADDICR = 6'b010000;
  localparam K_BAD = 6'b100000;

  // Classifies an instruction word into one of the kinds above.
  function [5:0] fpau_kind;
    input [31:0] word;
    begin
      case (word[`FPAU_PRIM_HI:`FPAU_PRIM_LO])
        `FPAU_PRIM_EXT: begin
          if (word[`FPAU_XO_HI:`FPAU_XO_LO] == `FPAU_XO_ADDE) begin
            fpau_kind = K_ADDE;
          end else if (word[`FPAU_XO_HI:`FPAU_XO_LO] == `FPAU_XO_ADDC) begin
            fpau_kind = K_ADDC;
          end else begin
            fpau_kind = K_BAD;
          end
        end
        `FPAU_PRIM_ADDI: fpau_kind = K_ADDI;
        `FPAU_PRIM_ADDIC: fpau_kind = K_ADDIC;
        `FPAU_PRIM_ADDICR: fpau_kind = K_ADDICR;
        default: fpau_kind = K_BAD;
      endcase
    end
  endfunction

  wire [5:0] kind;
  wire is_adde;
  wire is_addc;
  wire is_addi;
  wire is_addic;
  wire is_addicr;
  wire is_bad;
  wire is_xform;
  wire [4:0] src_a_idx;
  wire [DW-1:0] imm_ext;
  wire [DW-1:0] opnd_a;
  wire [DW-1:0] opnd_b;
  wire carry_in;
  wire [DW-1:0] sum;
  wire carry_out;
  wire overflow;
  wire sum_neg;
  wire sum_pos;
  wire sum_zero;
  wire upd_ca;
  wire upd_ov;
  wire upd_cr;
  wire next_so;

  assign kind = fpau_kind(issue_instr);
  assign is_adde = kind[0];
  assign is_addc = kind[1];
  assign is_addi = kind[2];
  assign is_addic = kind[3];
  assign is_addicr = kind[4];
  assign is_bad = kind[5];
  assign is_xform = is_adde | is_addc;
  assign src_a_idx = issue_instr[`FPAU_SRCA_HI:`FPAU_SRCA_LO];

  // Immediate is widened by copying its sign bit upward.
  assign imm_ext = {{(DW-16){issue_instr[`FPAU_IMM_SIGN]}},
                    issue_instr[`FPAU_IMM_HI:`FPAU_IMM_LO]};

  // Only the plain immediate add reads register zero as the value zero;
  // the carrying immediate forms always use the register contents.
  assign opnd_a = (is_addi && src_a_idx == `FPAU_REG_ZERO) ?
                  {DW{1'b0}} : src_first_val;
  assign opnd_b = is_xform ? src_second_val : imm_ext;

  // The stored carry flag feeds only the extended add.
  // Feeding it elsewhere would break the plain and immediate sums.
  assign carry_in = is_adde & unsigned_wrap_bit;

  fpau_sum #(
    .WIDTH(DW)
  ) u_sum (
    .opnd_a(opnd_a),
    .opnd_b(opnd_b),
    .carry_in(carry_in),
    .sum(sum),
    .carry_out(carry_out),
    .overflow(overflow),
    .is_neg(sum_neg),
    .is_pos(sum_pos),
    .is_zero(sum_zero)
  );

  // Which flags each operation is allowed to change.
  assign upd_ca = issue_valid & (is_xform | is_addic | is_addicr);
  assign upd_ov = issue_valid & is_xform & issue_instr[`FPAU_OE_BIT];
  assign upd_cr = issue_valid & ((is_xform & issue_instr[`FPAU_REC_BIT]) |
                  is_addicr);

  // Summary is sticky: an overflow with the OE bit set sets it, nothing in the datapath clears it.
  assign next_so = summary_bit | (upd_ov & overflow);

  // Result path, one cycle after issue. Unknown opcodes write nothing.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      res_valid <= 1'b0;
      res_write <= 1'b0;
      res_dest <= 5'h00;
      res_data <= {DW{1'b0}};
    end else begin
      res_valid <= issue_valid;
      res_write <= issue_valid & ~is_bad;
      if (issue_valid) begin
        res_dest <= issue_instr[`FPAU_DEST_HI:`FPAU_DEST_LO];
        res_data <= sum;
      end
    end
  end

  // APB handshake: the slave inserts one wait state so read data is a flop.
  // The cost is one extra cycle per access, which software never notices.
  reg ack;
  wire acc_phase;
  wire acc_first;
  wire wr_fire;
  wire rd_take;
  wire addr_ok;
  wire [7:0] off;
  wire [AW+7:0] addr_ext;

  // True when a byte offset names one of the four mapped words.
  function fpau_mapped;
    input [7:0] where;
    begin
      case (where)
        `FPAU_OFF_FLAGS: fpau_mapped = 1'b1;
        `FPAU_OFF_STATUS: fpau_mapped = 1'b1;
        `FPAU_OFF_CLEAR: fpau_mapped = 1'b1;
        `FPAU_OFF_ENABLE: fpau_mapped = 1'b1;
        default: fpau_mapped = 1'b0;
      endcase
    end
  endfunction

  // True for a committed write to the word at the given offset.
  function fpau_wr_hit;
    input fire;
    input ok;
    input [7:0] where;
    input [7:0] target;
    begin
      fpau_wr_hit = fire & ok & (where == target);
    end
  endfunction

  assign acc_phase = psel & penable;
  assign acc_first = acc_phase & ~ack;
  assign pready = ack;
  assign wr_fire = acc_phase & ack & pwrite;
  assign rd_take = acc_first & ~pwrite & addr_ok;

  // Padding the address with a zero byte keeps the upper-bit test legal
  // even when the bus carries no bits above the offset byte.
  assign addr_ext = {8'h00, paddr};
  assign off = addr_ext[7:0];
  assign addr_ok = (addr_ext[AW+7:8] == {AW{1'b0}}) && fpau_mapped(off);

  // Write strobes, one per writable word.
  wire sw_flags;
  wire sw_clear;
  wire sw_enable;
  assign sw_flags = fpau_wr_hit(wr_fire, addr_ok, off, `FPAU_OFF_FLAGS);
  assign sw_clear = fpau_wr_hit(wr_fire, addr_ok, off, `FPAU_OFF_CLEAR);
  assign sw_enable = fpau_wr_hit(wr_fire, addr_ok, off, `FPAU_OFF_ENABLE);

  // Flag registers. An issued operation owns the flags it updates in that
  // cycle; a software write to the flags word loads only the untouched ones.

  always @(posedge core_clk) begin
    if (!rst_n) begin
      unsigned_wrap_bit <= 1'b0;
      signed_wrap_bit <= 1'b0;
      summary_bit <= 1'b0;
    end else begin
      if (upd_ca) begin
        unsigned_wrap_bit <= carry_out;
      end else if (sw_flags) begin
        unsigned_wrap_bit <= pwdata[`FPAU_FLG_UWRAP];
      end
      if (upd_ov) begin
        signed_wrap_bit <= overflow;
        summary_bit <= next_so;
      end else if (sw_flags) begin
        signed_wrap_bit <= pwdata[`FPAU_FLG_SWRAP];
        summary_bit <= pwdata[`FPAU_FLG_SO];
      end
    end
  end

  // Compare field 0 follows recorded results only; software reads it.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      {neg_result_flag, pos_result_flag, zero_result_flag, cr0_summary} <= `FPAU_RST_CR;
      cr0_update <= 1'b0;
    end else begin
      cr0_update <= upd_cr;
      if (upd_cr) begin
        neg_result_flag <= sum_neg;
        pos_result_flag <= sum_pos;
        zero_result_flag <= sum_zero;
        cr0_summary <= upd_ov ? next_so : summary_bit;
      end
    end
  end

  // Event capture for the interrupt. Add-immediate raises no events.
  reg [`FPAU_EVT_W-1:0] evt_status;
  reg [`FPAU_EVT_W-1:0] evt_enable;
  wire [`FPAU_EVT_W-1:0] evt_raise;
  wire [`FPAU_EVT_W-1:0] evt_clear;
  wire [`FPAU_EVT_W-1:0] next_status;

  assign evt_raise[`FPAU_EVT_OVF] = upd_ov & overflow;
  assign evt_raise[`FPAU_EVT_CARRY] = upd_ca & carry_out;
  assign evt_raise[`FPAU_EVT_BADOP] = issue_valid & is_bad;
  assign evt_clear = sw_clear ? pwdata[`FPAU_EVT_W-1:0] : {`FPAU_EVT_W{1'b0}};

  // A new event in the clearing cycle survives the clear.
  genvar gi;
  generate
    for (gi = 0; gi < `FPAU_EVT_W; gi = gi + 1) begin : g_evt
      assign next_status[gi] = evt_raise[gi] | (evt_status[gi] & ~evt_clear[gi]);
    end
  endgenerate

  always @(posedge core_clk) begin
    if (!rst_n) begin
      evt_status <= `FPAU_RST_EVT;
      evt_enable <= `FPAU_RST_EVT;
    end else begin
      evt_status <= next_status;
      if (sw_enable) begin
        evt_enable <= pwdata[`FPAU_EVT_W-1:0];
      end
    end
  end

  // Level interrupt while any enabled event is pending.
  assign irq = |(evt_status & evt_enable);

  // Read mux. Reserved bits and write-only clear read as zero.
  reg [31:0] next_rdata;
  always @* begin
    next_rdata = `FPAU_RST_WORD;
    case (off)
      `FPAU_OFF_FLAGS: begin
        next_rdata[`FPAU_FLG_UWRAP] = unsigned_wrap_bit;
        next_rdata[`FPAU_FLG_SWRAP] = signed_wrap_bit;
        next_rdata[`FPAU_FLG_SO] = summary_bit;
        next_rdata[`FPAU_FLG_CR_HI:`FPAU_FLG_CR_LO] =
          {neg_result_flag, pos_result_flag, zero_result_flag, cr0_summary};
      end
      `FPAU_OFF_STATUS: next_rdata[`FPAU_EVT_W-1:0] = evt_status;
      `FPAU_OFF_ENABLE: next_rdata[`FPAU_EVT_W-1:0] = evt_enable;
      default: next_rdata = `FPAU_RST_WORD;
    endcase
  end

  // Ack comes in the second access cycle; unmapped addresses answer an error.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      ack <= 1'b0;
      prdata <= `FPAU_RST_WORD;
      pslverr <= 1'b0;
    end else begin
      ack <= acc_first;
      pslverr <= acc_first & ~addr_ok;
      if (rd_take) begin
        prdata <= next_rdata;
      end else if (acc_first) begin
        prdata <= `FPAU_RST_WORD;
      end
    end
  end

endmodule

// file: verif/fpau_top_sva.sv
// Port assertions for the fixed-point add unit.
// Assumes the bind below attaches it to every fpau_top instance.
`timescale 1ns/1ps
`include "fpau_regs.vh"
module fpau_chk #(
  parameter AW = 8,
  parameter DW = 32
) (
  input wire core_clk,
  input wire rst_n,
  input wire issue_valid,
  input wire [31:0] issue_instr,
  input wire [DW-1:0] src_first_val,
  input wire [DW-1:0] src_second_val,
  input wire [DW-1:0] res_data,
  input wire cr0_update,
  input wire unsigned_wrap_bit,
  input wire signed_wrap_bit,
  input wire summary_bit,
  input wire neg_result_flag,
  input wire pos_result_flag,
  input wire zero_result_flag,
  input wire cr0_summary
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Decoded fields of the word being issued.
  wire [5:0] prim = issue_instr[31:26];
  wire [8:0] xo = issue_instr[9:1];
  wire [DW-1:0] imm = {{(DW-16){issue_instr[15]}}, issue_instr[15:0]};
  sequence s_xadd;
    issue_valid && prim == `FPAU_PRIM_EXT && (xo == `FPAU_XO_ADDE || xo == `FPAU_XO_ADDC);
  endsequence
  sequence s_addi;
    issue_valid && prim == `FPAU_PRIM_ADDI;
  endsequence
  property p_adde;
    issue_valid && prim == `FPAU_PRIM_EXT && xo == `FPAU_XO_ADDE |=> res_data ==
      $past(src_first_val) + $past(src_second_val) + $past(unsigned_wrap_bit);
  endproperty
  a_adde: assert property (p_adde) else $error("extended sum wrong");
  // A carry out shows as a sum that wrapped below the first operand, or that
  // came back to it exactly when a carry was added in by the extended form.
  property p_xcarry;
    s_xadd |=> unsigned_wrap_bit == (res_data < $past(src_first_val) ||
      ($past(xo) == `FPAU_XO_ADDE && $past(unsigned_wrap_bit) &&
      res_data == $past(src_first_val)));
  endproperty
  a_xcarry: assert property (p_xcarry) else $error("carry flag wrong");
  property p_oe_off;
    s_xadd ##0 !issue_instr[10] |=> $stable(signed_wrap_bit) && $stable(summary_bit);
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("overflow flags moved");
  property p_sticky;
    s_xadd ##0 issue_instr[10] |=> !signed_wrap_bit || summary_bit;
  endproperty
  a_sticky: assert property (p_sticky) else $error("summary not set");
  property p_rec;
    s_xadd ##0 issue_instr[0] |=> cr0_update && cr0_summary == summary_bit;
  endproperty
  a_rec: assert property (p_rec) else $error("compare field not written");
  property p_cr_val;
    cr0_update |-> neg_result_flag == res_data[DW-1] && zero_result_flag == (res_data == 0)
      && pos_result_flag == !(res_data[DW-1] || res_data == 0);
  endproperty
  a_cr_val: assert property (p_cr_val) else $error("compare flags wrong");
  property p_addi;
    s_addi |=> res_data == ($past(issue_instr[20:16]) == 5'h00 ? {DW{1'b0}} :
      $past(src_first_val)) + $past(imm) && !cr0_update && $stable(unsigned_wrap_bit)
      && $stable(signed_wrap_bit) && $stable(summary_bit);
  endproperty
  a_addi: assert property (p_addi) else $error("addi wrong");
  property p_addic;
    issue_valid && prim == `FPAU_PRIM_ADDIC |=> res_data == $past(src_first_val) + $past(imm)
      && !cr0_update && unsigned_wrap_bit == (res_data < $past(src_first_val));
  endproperty
  a_addic: assert property (p_addic) else $error("addic bad");
  property p_addicr;
    issue_valid && prim == `FPAU_PRIM_ADDICR |=> cr0_update
      && res_data == $past(src_first_val) + $past(imm)
      && unsigned_wrap_bit == (res_data < $past(src_first_val));
  endproperty
  a_addicr: assert property (p_addicr) else $error("recording add wrong");
endmodule
bind fpau_top fpau_chk #(.AW(AW), .DW(DW)) chk (.core_clk, .rst_n, .issue_valid, .issue_instr,
  .src_first_val, .src_second_val, .res_data, .cr0_update, .unsigned_wrap_bit, .signed_wrap_bit,
  .summary_bit, .neg_result_flag, .pos_result_flag, .zero_result_flag, .cr0_summary);

// file: verif/fpau_gpr_model.sv
// Decoder and register file model that feeds the add unit.
// Assumes the bench loads registers at a clock edge and strobes send.
`timescale 1ns/1ps
module fpau_reg_model (
  input wire core_clk,
  input wire send,
  input wire [31:0] send_instr,
  output wire issue_valid,
  output wire [31:0] issue_instr,
  output wire [31:0] src_first_val,
  output wire [31:0] src_second_val,
  input wire res_valid,
  input wire res_write,
  input wire [4:0] res_dest
  ,input wire [31:0] res_data
);
  logic [31:0] regs [0:31];
  initial foreach (regs[i]) regs[i] = 32'h0;
  // Operands are inverted outside a strobe so a late read cannot pass by luck.
  assign issue_valid = send;
  assign issue_instr = send_instr;
  assign src_first_val = send ? regs[send_instr[20:16]] : ~regs[send_instr[20:16]];
  assign src_second_val = send ? regs[send_instr[15:11]] : ~regs[send_instr[15:11]];
  // Results land in the file in the cycle the unit offers them.
  always @(posedge core_clk) begin
    if (res_valid && res_write) begin
      regs[res_dest] <= res_data;
    end
  end
  task set_reg(input logic [4:0] idx, input logic [31:0] val);
    regs[idx] <= val;
  endtask
endmodule

// file: verif/fpau_top_bench.sv
// Self-checking bench for the add unit, with APB tasks and a register file model.
// Assumes the checker is bound in and destinations never feed the next operation.
`timescale 1ns/1ps
`include "fpau_regs.vh"
module fpau_top_bench;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, send = 1'b0, er;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, send_instr = 32'h0, rd;
  wire [31:0] prdata, i_ins, va, vb, res_data;
  wire pready, pslverr, irq, iv, res_valid, res_write, cr0_update, uw, sw, sm, fn, fp, fz, cs;
  wire [4:0] res_dest;
  int num_errors = 0;
  int total_checks = 0;
  always #2.5 core_clk = ~core_clk;
  fpau_top dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .issue_valid(iv), .issue_instr(i_ins), .src_first_val(va),
    .src_second_val(vb), .res_valid(res_valid), .res_write(res_write), .res_dest(res_dest),
    .res_data(res_data), .cr0_update(cr0_update), .unsigned_wrap_bit(uw),
    .signed_wrap_bit(sw), .summary_bit(sm), .neg_result_flag(fn), .pos_result_flag(fp),
    .zero_result_flag(fz), .cr0_summary(cs));
  fpau_reg_model mdl (.core_clk(core_clk), .send(send), .send_instr(send_instr),
    .issue_valid(iv), .issue_instr(i_ins), .src_first_val(va), .src_second_val(vb),
    .res_valid(res_valid), .res_write(res_write), .res_dest(res_dest), .res_data(res_data));
  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; read data and error are taken at the ready edge only.
  // A slave that never answers is ended by the watchdog, not here.
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) begin
      @(posedge core_clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  function logic [31:0] xf(input logic [8:0] x, input logic oe, input logic rec);
    return {6'h1f, 5'h06, 5'h04, 5'h0a, oe, x, rec};
  endfunction
  function logic [31:0] im(input logic [5:0] p, input logic [4:0] src, input logic [15:0] v);
    return {p, 5'h07, src, v};
  endfunction
  task op(input logic [31:0] ins, input logic [31:0] a, input logic [31:0] b);
    @(posedge core_clk);
    mdl.set_reg(ins[20:16], a);
    if (ins[31:26] == `FPAU_PRIM_EXT) mdl.set_reg(ins[15:11], b);
    send <= 1'b1;
    send_instr <= ins;
    @(posedge core_clk);
    send <= 1'b0;
    #1;
    chk_word({31'h0, res_valid}, 32'h1);
  endtask
  // Result, wrap flags and, when recorded, the compare field from the expected sum.
  task xcase(input logic [31:0] ins, input logic [31:0] a, input logic [31:0] b,
    input logic [31:0] e, input logic [2:0] fl, input logic rec);
    op(ins, a, b);
    chk_word(res_data, e);
    chk_word({31'h0, res_write}, 32'h1);
    chk_word({27'h0, res_dest}, {27'h0, ins[25:21]});
    chk_word({29'h0, uw, sw, sm}, {29'h0, fl});
    chk_word({31'h0, cr0_update}, {31'h0, rec});
    if (rec) chk_word({28'h0, fn, fp, fz, cs}, {28'h0, e[31], !e[31] && e != 0, e == 0, fl[0]});
  endtask
  task t_reset;
    apb(1'b0, `FPAU_OFF_FLAGS, 32'h0);
    chk_word(rd, 32'h0);
    apb(1'b0, `FPAU_OFF_STATUS, 32'h0);
    chk_word(rd, 32'h0);
    apb(1'b0, `FPAU_OFF_ENABLE, 32'h0);
    chk_word({rd[30:0], irq}, 32'h0);
    $display("reset test done");
  endtask
  task t_xform;
    xcase(xf(9'h00a, 0, 0), 32'h90003000, 32'h80007000, 32'h1000a000, 3'h4, 0);
    xcase(xf(9'h08a, 1, 0), 32'h10000400, 32'hefffffff, 32'h00000400, 3'h4, 0);
    xcase(xf(9'h08a, 0, 0), 32'h10000400, 32'h10000400, 32'h20000801, 3'h0, 0);
    xcase(xf(9'h08a, 0, 1), 32'h90003000, 32'h7b4192c0, 32'h0b41c2c0, 3'h4, 1);
    xcase(xf(9'h00a, 0, 0), 32'h80000000, 32'h80007000, 32'h00007000, 3'h4, 0);
    xcase(xf(9'h00a, 1, 1), 32'h80000000, 32'h80007000, 32'h00007000, 3'h7, 1);
    xcase(xf(9'h00a, 1, 0), 32'h90003000, 32'h7b4192c0, 32'h0b41c2c0, 3'h5, 0);
    apb(1'b0, `FPAU_OFF_FLAGS, 32'h0);
    chk_word(rd, 32'h00000055);
    $display("register form test done");
  endtask
  task t_imm;
    xcase(im(6'h0d, 5'h04, 16'h1000), 32'hefffffff, 0, 32'hf0000fff, 3'h1, 1);
    xcase(im(6'h0c, 5'h04, 16'hffff), 32'h00002346, 0, 32'h00002345, 3'h5, 0);
    xcase(im(6'h0c, 5'h00, 16'h0001), 32'h12345678, 0, 32'h12345679, 3'h1, 0);
    xcase(im(6'h0e, 5'h05, 16'h8ff0), 32'h00000900, 0, 32'hffff98f0, 3'h1, 0);
    xcase(im(6'h0e, 5'h00, 16'h8ff0), 32'h12345678, 0, 32'hffff8ff0, 3'h1, 0);
    $display("immediate test done");
  endtask
  // Events, masking and clearing of the interrupt, and an unmapped access.
  task t_irq;
    op(32'h0, 32'h0, 32'h0);
    chk_word({31'h0, res_write}, 32'h0);
    apb(1'b0, `FPAU_OFF_STATUS, 32'h0);
    chk_word(rd, 32'h7);
    apb(1'b1, `FPAU_OFF_ENABLE, 32'h4);
    chk_word({31'h0, irq}, 32'h1);
    apb(1'b0, `FPAU_OFF_ENABLE, 32'h0);
    chk_word(rd, 32'h4);
    apb(1'b1, `FPAU_OFF_CLEAR, 32'h4);
    chk_word({31'h0, irq}, 32'h0);
    apb(1'b0, `FPAU_OFF_STATUS, 32'h0);
    chk_word(rd, 32'h3);
    apb(1'b0, `FPAU_OFF_CLEAR, 32'h0);
    chk_word(rd, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk_word({rd[30:0], er}, 32'h1);
    $display("interrupt test done");
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Reset is held for ten edges, then the scenarios run in order.
  initial begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_xform();
    t_imm();
    t_irq();
    complete_run();
  end
  // The whole run needs well under a thousand cycles; this cuts a hang short.
  initial begin
    #20000;
    num_errors++;
    complete_run();
  end
endmodule
